// file: bench/lpp_panel_model.sv
module lpp_panel_model (
    input  wire logic clock_i,     // System clock
    input  wire logic supply_i,    // Panel supply
    input  wire logic data_on_i,   // Lanes driven
    input  wire logic backlight_i, // Backlight
    output logic      bad_o        // Sequence broken
);
    timeunit 1ns;
    timeprecision 1ps;
    // One driver for the flag, cleared at start
    logic bad_ff = 1'b0;
    assign bad_o = bad_ff;
    // lamp needs fed panel; a lit dark panel can be damaged
    always @(posedge clock_i) begin
        if (backlight_i && !(supply_i && data_on_i)) begin
            bad_ff <= 1'b1;
        end
    end
endmodule

// file: bench/lpp_top_properties.sv
module lpp_top_properties
    import lpp_pkg::*;
#(
    parameter int MS_CYC_P = MS_CYC
) (
    input wire logic            clock_i,            // Clock
    input wire logic            sys_rst_i,          // Reset
    input wire logic [7:0]      reg_addr_i,         // Address
    input wire logic [7:0]      reg_wdata_i,        // Write data
    input wire logic            reg_wr_i,           // Write strobe
    input wire logic            reg_rd_i,           // Read strobe
    input wire logic [7:0]      reg_rdata_o,        // Read data
    input wire logic [3:0][6:0] serial_lane_o,      // Lanes
    input wire logic            serial_lane_oe_o,   // Lane enable
    input wire logic            panel_supply_en_o,  // Supply
    input wire logic            backlight_en_out_o, // Backlight
    input wire logic            standby_o           // Standby
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] off_ff;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    // Cycles since supply fell; reset counts as a long gap
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            off_ff <= 16'hFFFF;
        end else if (panel_supply_en_o) begin
            off_ff <= 16'h0000;
        end else if (off_ff != 16'hFFFF) begin
            off_ff <= off_ff + 16'h0001;
        end
    end
    property p_bl_needs_data;
        backlight_en_out_o |-> serial_lane_oe_o && panel_supply_en_o;
    endproperty
    a_bl_needs_data: assert property (p_bl_needs_data) else $error("backlight early");
    property p_live_needs_supply;
        serial_lane_o != '0 |-> panel_supply_en_o && serial_lane_oe_o;
    endproperty
    a_live_needs_supply: assert property (p_live_needs_supply) else $error("lanes live");
    property p_idle_low;
        !serial_lane_oe_o |-> serial_lane_o == '0;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("lanes not low");
    property p_off_order;
        $fell(panel_supply_en_o) |-> !backlight_en_out_o && serial_lane_o == '0;
    endproperty
    a_off_order: assert property (p_off_order) else $error("off order");
    property p_t5_gap;
        $rose(panel_supply_en_o) |-> off_ff >= 16'(2 * MS_CYC_P);
    endproperty
    a_t5_gap: assert property (p_t5_gap) else $error("restart too soon");
    property p_clkdef_read;
        reg_rd_i && reg_addr_i == ADR_CLKDET |=> (reg_rdata_o & 8'hFB) == 8'h00;
    endproperty
    a_clkdef_read: assert property (p_clkdef_read) else $error("reserved bits");
    property p_standby;
        reg_wr_i && reg_addr_i == ADR_LVDSPD && reg_wdata_i[B_LVDSPD] |-> ##[1:2] standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby");
    property p_sw_off;
        reg_wr_i && reg_addr_i == ADR_PROT && !reg_wdata_i[B_PANEL_ON_REQUEST] |-> ##[1:4] !backlight_en_out_o;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("backlight stays");
    property p_bl_allow;
        reg_wr_i && reg_addr_i == ADR_PROT && !reg_wdata_i[B_BLALLOW]
            |=> ##3 !backlight_en_out_o [*4];
    endproperty
    a_bl_allow: assert property (p_bl_allow) else $error("backlight not allowed");
    c_on: cover property ($rose(backlight_en_out_o));
    c_off: cover property ($fell(panel_supply_en_o));
    c_standby: cover property ($rose(standby_o));
endmodule

bind lpp_top lpp_top_properties #(.MS_CYC_P(MS_CYC_P)) chk_u (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .serial_lane_o(serial_lane_o),
    .serial_lane_oe_o(serial_lane_oe_o), .panel_supply_en_o(panel_supply_en_o),
    .backlight_en_out_o(backlight_en_out_o), .standby_o(standby_o)
);

// file: bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpp_pkg::*;
    logic            clock_i = 1'b0;
    logic            sys_rst_i = 1'b1;
    logic [7:0]      reg_addr_i = 8'h00;
    logic [7:0]      reg_wdata_i = 8'h00;
    logic            reg_wr_i = 1'b0;
    logic            reg_rd_i = 1'b0;
    logic [7:0]      reg_rdata_o;
    logic            pixel_clock_in_i = 1'b0;
    lpp_pix_s        pix_i = '0;
    logic            pll_lock_i = 1'b1;
    logic [3:0][6:0] serial_lane_o;
    logic            serial_lane_oe_o, panel_supply_en_o, backlight_en_out_o;
    logic            standby_o, panel_bad;
    logic [1:0]      div = 2'd0;
    logic [7:0]      px = 8'd0;
    logic [2:0]      pw;
    int              err_total = 0;
    int              checks_done = 0;
    assign pw = {backlight_en_out_o, serial_lane_oe_o, panel_supply_en_o};

    lpp_top #(.MS_CYC_P(50)) dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pixel_clock_in_i(pixel_clock_in_i), .pix_i(pix_i),
        .pll_lock_i(pll_lock_i), .serial_lane_o(serial_lane_o),
        .serial_lane_oe_o(serial_lane_oe_o), .panel_supply_en_o(panel_supply_en_o),
        .backlight_en_out_o(backlight_en_out_o), .standby_o(standby_o)
    );
    lpp_panel_model panel_u (
        .clock_i(clock_i), .supply_i(panel_supply_en_o), .data_on_i(serial_lane_oe_o),
        .backlight_i(backlight_en_out_o), .bad_o(panel_bad)
    );

    initial forever #20 clock_i = ~clock_i;
    // Pixel clock of 320 ns; frames of 8 lines, 20 pixels each
    always @(posedge clock_i) begin
        div <= div + 2'd1;
        if (div == 2'd3) begin
            pixel_clock_in_i <= ~pixel_clock_in_i;
        end
        if (div == 2'd3 && pixel_clock_in_i) begin
            px <= (px == 8'd159) ? 8'd0 : px + 8'd1;
            pix_i <= '{r: 8'h96, g: 8'h3C, b: 8'hE1, hs: (px % 20) < 2,
                       vs: px < 20, de: (px % 20) > 3};
        end
    end
    // Lanes for the fixed pixel: 0 SPWG, 1 open-LDI, 2 narrow
    function automatic logic [27:0] lanes(input int m);
        logic [7:0] r, g, b;
        r = 8'h96;
        g = 8'h3C;
        b = 8'hE1;
        if (m == 0) begin
            return {1'b0, b[7:6], g[7:6], r[7:6], 3'h0, b[5:2], b[1:0], g[5:1], g[0], r[5:0]};
        end
        return {1'b0, (m == 1) ? {b[1:0], g[1:0], r[1:0]} : 6'h00, 3'h0, b[7:4],
                b[3:2], g[7:3], g[2], r[7:2]};
    endfunction
    task automatic chk(input logic [27:0] got, input logic [27:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk(28'(reg_rdata_o), 28'(e));
    endtask
    // Bounded wait for a supply, data, backlight pattern
    task automatic wait_pw(input logic [2:0] e, input int lim);
        int n;
        n = 0;
        while (pw !== e && n < lim) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk(28'(pw), 28'(e));
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd(ADR_TPON_L, 8'h14);
        rd(ADR_TPPWD, 8'h0A);
        rd(ADR_ULIMIT, 8'hFF);
        rd(8'h4A, 8'h00);
        wr(ADR_CLKDET, 8'hFF);
        rd(ADR_CLKDET, 8'h04);
        wr(ADR_CLKDET, 8'h00);
        $display("test registers done");
        // Short timers; backlight not yet allowed
        wr(ADR_TPON_L, 8'h02);
        wr(ADR_TPBLE, 8'h01);
        wr(ADR_TPBLD, 8'h01);
        wr(ADR_TPOFF, 8'h02);
        wr(ADR_TPPWD, 8'h01);
        wr(ADR_PROT, 8'h01);
        wait_pw(3'b001, 8000);
        wait_pw(3'b011, 400);
        repeat (300) @(posedge clock_i);
        #1;
        chk(28'(pw), 28'h3);
        wr(ADR_PROT, 8'h21);
        wait_pw(3'b111, 20);
        for (int m = 0; m < 3; m++) begin
            wr(ADR_FORMAT, (m == 0) ? 8'h20 : (m == 1) ? 8'h21 : 8'h08);
            repeat (40) @(posedge clock_i);
            #1;
            chk(serial_lane_o & 28'hFE3FFFF, lanes(m));
        end
        $display("test power on and lanes done");
        // Lock lost: ordered shutdown, restart held off by T5
        @(posedge clock_i) pll_lock_i <= 1'b0;
        wait_pw(3'b011, 100);
        wait_pw(3'b001, 400);
        chk(serial_lane_o, 28'h0);
        wait_pw(3'b000, 400);
        @(posedge clock_i) pll_lock_i <= 1'b1;
        repeat (2000) @(posedge clock_i);
        #1;
        chk(28'(pw), 28'h0);
        wait_pw(3'b111, 1500);
        // Limit of zero judges the clock unstable at once
        wr(ADR_ULIMIT, 8'h00);
        wait_pw(3'b000, 1000);
        $display("test protection done");
        // Force bit alone keeps the lock check; both bits defeat it
        @(posedge clock_i) pll_lock_i <= 1'b0;
        wr(ADR_PROT, 8'h29);
        wait_pw(3'b000, 1000);
        repeat (2600) @(posedge clock_i);
        #1;
        chk(28'(pw), 28'h0);
        wr(ADR_PROT, 8'h39);
        wait_pw(3'b111, 800);
        wr(ADR_PROT, 8'h38);
        wait_pw(3'b000, 800);
        wr(ADR_DRIVER, 8'h80);
        wr(ADR_LVDSPD, 8'h40);
        repeat (2) @(posedge clock_i);
        #1;
        chk(28'(standby_o), 28'h1);
        chk(28'(pw), 28'h2);
        chk(28'(panel_bad), 28'h0);
        $display("test bypass and standby done");
        complete_run();
    end
    // Watchdog, about four times the expected run
    initial begin
        repeat (40000) @(posedge clock_i);
        err_total++;
        complete_run();
    end
endmodule

// file: hdl/lpp_pkg.sv
package lpp_pkg;
    // Clock and derived timing counts
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1_000_000;
    localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
    localparam int HS_MISS_NS    = 32_000;
    localparam int HS_MISS_CYC   = HS_MISS_NS / CLK_PERIOD_NS;
    localparam int CLK_MISS_NS   = 1_200;
    localparam int CLK_MISS_CYC  = CLK_MISS_NS / CLK_PERIOD_NS;

    // Sequencer timer steps and floor, in ms
    localparam int T1_STEP_MS = 1;
    localparam int T2_STEP_MS = 2;
    localparam int T3_STEP_MS = 2;
    localparam int T4_STEP_MS = 1;
    localparam int T5_STEP_MS = 50;
    localparam int T_MIN_MS   = 2;

    // Register offsets
    localparam logic [7:0] ADR_CLKDET = 8'h14;
    localparam logic [7:0] ADR_LVDSPD = 8'h63;
    localparam logic [7:0] ADR_FORMAT = 8'h64;
    localparam logic [7:0] ADR_PROT   = 8'h66;
    localparam logic [7:0] ADR_TPON_L = 8'h67;
    localparam logic [7:0] ADR_TPBLE  = 8'h68;
    localparam logic [7:0] ADR_TPBLD  = 8'h69;
    localparam logic [7:0] ADR_TPOFF  = 8'h6A;
    localparam logic [7:0] ADR_TPPWD  = 8'h6B;
    localparam logic [7:0] ADR_DRIVER = 8'h74;
    localparam logic [7:0] ADR_PLLPD  = 8'h76;
    localparam logic [7:0] ADR_ULIMIT = 8'h7F;

    // Field positions
    localparam int B_CLKDEF  = 2;
    localparam int B_LVDSPD  = 6;
    localparam int B_WIDE    = 5;
    localparam int B_DDEF    = 3;
    localparam int B_LDI     = 0;
    localparam int B_PANEL_ON_REQUEST   = 0;
    localparam int B_SYNCBYP = 1;
    localparam int B_LOCK    = 2;
    localparam int B_LFORCE  = 3;
    localparam int B_LBYPEN  = 4;
    localparam int B_BLALLOW = 5;
    localparam int B_SYNCST  = 6;
    localparam int B_HI      = 7;
    localparam int B_PULLDN  = 7;
    localparam int B_PLLPD   = 3;

    // Reset values
    localparam logic [8:0] RST_TPON   = 9'h014;
    localparam logic [6:0] RST_TPBLE  = 7'h05;
    localparam logic [6:0] RST_TPBLD  = 7'h05;
    localparam logic [8:0] RST_TPOFF  = 9'h014;
    localparam logic [5:0] RST_TPPWD  = 6'h0A;
    localparam logic [7:0] RST_ULIMIT = 8'hFF;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic       hs;
        logic       vs;
        logic       de;
    } lpp_pix_s;

    typedef enum logic [2:0] {
        SQ_OFF, SQ_T1, SQ_T2, SQ_ON, SQ_T3, SQ_T4, SQ_T5
    } lpp_seq_e;
endpackage

// file: hdl/lpp_top.sv
// Two-flop synchroniser with synchronous clear
//
// Local design decisions: the plain strobed port and the placing of the registers.
module lpp_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_i,    // System clock
    input  wire logic         sys_rst_i,  // Sync reset
    input  wire logic [W-1:0] d_i,        // Async input
    output logic      [W-1:0] q_o         // Synchronised
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

module lpp_top #(
    parameter int MS_CYC_P = lpp_pkg::MS_CYC
) (
    input  wire logic             clock_i,            // 25 MHz clock
    input  wire logic             sys_rst_i,          // Sync reset, high
    input  wire logic [7:0]       reg_addr_i,         // Register offset
    input  wire logic [7:0]       reg_wdata_i,        // Write data
    input  wire logic             reg_wr_i,           // Write strobe
    input  wire logic             reg_rd_i,           // Read strobe
    output logic      [7:0]       reg_rdata_o,        // Read data, next cycle
    input  wire logic             pixel_clock_in_i,   // Pixel clock pin
    input  wire lpp_pkg::lpp_pix_s pix_i,             // Pixel, syncs, enable
    input  wire logic             pll_lock_i,         // PLL lock level
    output logic      [3:0][6:0]  serial_lane_o,      // Lane slots, bit0=slot1
    output logic                  serial_lane_oe_o,   // Lane drive enable
    output logic                  panel_supply_en_o,  // Panel supply enable
    output logic                  backlight_en_out_o, // Backlight enable
    output logic                  standby_o           // Low-current standby
);
    import lpp_pkg::*;

    // Control registers
    logic       clk_def_ff, lvds_pd_ff, wide_ff, ddef_ff, ldi_ff;
    logic       panel_on_request_ff, sync_byp_ff, lforce_ff, lbypen_ff, bl_allow_ff;
    logic       pulldn_ff, pll_pd_ff;
    logic [8:0] tpon_ff, tpoff_ff;
    logic [6:0] tpble_ff, tpbld_ff;
    logic [5:0] tppwd_ff;
    logic [7:0] ulimit_ff;

    // Synchronised pins
    logic      pck_s, lk_s;
    lpp_pix_s  pix_s;

    lpp_sync #(.W(2)) u_sync_ctl (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .d_i       ({pixel_clock_in_i, pll_lock_i}),
        .q_o       ({pck_s, lk_s})
    );

    lpp_sync #(.W($bits(lpp_pix_s))) u_sync_pix (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (pix_i),
        .q_o       (pix_s)
    );

    // Register write decode
    wire wr_clkdet = reg_wr_i && (reg_addr_i == ADR_CLKDET);
    wire wr_lvdspd = reg_wr_i && (reg_addr_i == ADR_LVDSPD);
    wire wr_format = reg_wr_i && (reg_addr_i == ADR_FORMAT);
    wire wr_prot   = reg_wr_i && (reg_addr_i == ADR_PROT);
    wire wr_tponl  = reg_wr_i && (reg_addr_i == ADR_TPON_L);
    wire wr_tpble  = reg_wr_i && (reg_addr_i == ADR_TPBLE);
    wire wr_tpbld  = reg_wr_i && (reg_addr_i == ADR_TPBLD);
    wire wr_tpoff  = reg_wr_i && (reg_addr_i == ADR_TPOFF);
    wire wr_tppwd  = reg_wr_i && (reg_addr_i == ADR_TPPWD);
    wire wr_driver = reg_wr_i && (reg_addr_i == ADR_DRIVER);
    wire wr_pllpd  = reg_wr_i && (reg_addr_i == ADR_PLLPD);
    wire wr_ulimit = reg_wr_i && (reg_addr_i == ADR_ULIMIT);

    // Register storage; values kept across standby
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            clk_def_ff  <= 1'b0;
            lvds_pd_ff  <= 1'b0;
            wide_ff     <= 1'b0;
            ddef_ff     <= 1'b0;
            ldi_ff      <= 1'b0;
            panel_on_request_ff    <= 1'b0;
            sync_byp_ff <= 1'b0;
            lforce_ff   <= 1'b0;
            lbypen_ff   <= 1'b0;
            bl_allow_ff <= 1'b0;
            pulldn_ff   <= 1'b0;
            pll_pd_ff   <= 1'b0;
            tpon_ff     <= RST_TPON;
            tpble_ff    <= RST_TPBLE;
            tpbld_ff    <= RST_TPBLD;
            tpoff_ff    <= RST_TPOFF;
            tppwd_ff    <= RST_TPPWD;
            ulimit_ff   <= RST_ULIMIT;
        end else begin
            if (wr_clkdet) clk_def_ff <= reg_wdata_i[B_CLKDEF];
            if (wr_lvdspd) lvds_pd_ff <= reg_wdata_i[B_LVDSPD];
            if (wr_pllpd)  pll_pd_ff  <= reg_wdata_i[B_PLLPD];
            if (wr_format) begin
                wide_ff <= reg_wdata_i[B_WIDE];
                ddef_ff <= reg_wdata_i[B_DDEF];
                ldi_ff  <= reg_wdata_i[B_LDI];
            end
            if (wr_prot) begin
                panel_on_request_ff    <= reg_wdata_i[B_PANEL_ON_REQUEST];
                sync_byp_ff <= reg_wdata_i[B_SYNCBYP];
                lforce_ff   <= reg_wdata_i[B_LFORCE];
                lbypen_ff   <= reg_wdata_i[B_LBYPEN];
                bl_allow_ff <= reg_wdata_i[B_BLALLOW];
            end
            if (wr_tponl) tpon_ff[7:0] <= reg_wdata_i;
            if (wr_tpble) begin
                tpon_ff[8] <= reg_wdata_i[B_HI];
                tpble_ff   <= reg_wdata_i[6:0];
            end
            if (wr_tpbld) begin
                tpoff_ff[8] <= reg_wdata_i[B_HI];
                tpbld_ff    <= reg_wdata_i[6:0];
            end
            if (wr_tpoff)  tpoff_ff[7:0] <= reg_wdata_i;
            if (wr_tppwd)  tppwd_ff      <= reg_wdata_i[5:0];
            if (wr_driver) pulldn_ff     <= reg_wdata_i[B_PULLDN];
            if (wr_ulimit) ulimit_ff     <= reg_wdata_i;
        end
    end

    // Pixel clock edges and sampled pixel
    logic       pck_d_ff;
    lpp_pix_s   px_ff;
    logic       hs_d_ff, vs_d_ff, lk_d_ff;
    wire        pck_rise = pck_s && !pck_d_ff;
    wire        hs_rise  = px_ff.hs && !hs_d_ff;
    wire        vs_rise  = px_ff.vs && !vs_d_ff;
    wire        unlock_ev = lk_d_ff && !lk_s;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pck_d_ff <= 1'b0;
            px_ff    <= '0;
            hs_d_ff  <= 1'b0;
            vs_d_ff  <= 1'b0;
            lk_d_ff  <= 1'b0;
        end else begin
            pck_d_ff <= pck_s;
            hs_d_ff  <= px_ff.hs;
            vs_d_ff  <= px_ff.vs;
            lk_d_ff  <= lk_s;
            if (pck_rise) px_ff <= pix_s;
        end
    end

    // Missing-signal watchdogs
    logic [4:0]  cmiss_ff;
    logic [9:0]  hmiss_ff;
    wire         clk_missing = (cmiss_ff == 5'(CLK_MISS_CYC));
    wire         hs_missing  = (hmiss_ff == 10'(HS_MISS_CYC));

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmiss_ff <= 5'(CLK_MISS_CYC);
            hmiss_ff <= 10'(HS_MISS_CYC);
        end else begin
            cmiss_ff <= pck_rise ? 5'h00 : (clk_missing ? cmiss_ff : cmiss_ff + 5'h01);
            hmiss_ff <= hs_rise ? 10'h000 : (hs_missing ? hmiss_ff : hmiss_ff + 10'h001);
        end
    end

    // Line counting per frame, three-frame history
    logic [11:0] lines_ff, h0_ff, h1_ff, h2_ff;
    logic [7:0]  ucnt_ff;
    logic        pll_bad_ff, sync_ok_ff;
    wire         vs_missing = ({1'b0, lines_ff} >= {h0_ff, 1'b0});
    wire         counts_eq = (h0_ff == h1_ff) && (h1_ff == h2_ff) && (h0_ff != 12'h000);
    wire         nxt_sync_ok = counts_eq && !vs_missing && !hs_missing;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            lines_ff <= 12'h000;
            h0_ff    <= 12'h000;
            h1_ff    <= 12'h000;
            h2_ff    <= 12'h000;
        end else if (vs_rise) begin
            h0_ff    <= lines_ff;
            h1_ff    <= h0_ff;
            h2_ff    <= h1_ff;
            lines_ff <= 12'h000;
        end else if (hs_rise && (lines_ff != 12'hFFF)) begin
            lines_ff <= lines_ff + 12'h001;
        end
    end

    // Unlock events counted per frame, judged against the limit
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ucnt_ff    <= 8'h00;
            pll_bad_ff <= 1'b0;
            sync_ok_ff <= 1'b0;
        end else begin
            if (vs_rise) begin
                ucnt_ff <= 8'h00;
            end else if (unlock_ev && (ucnt_ff != 8'hFF)) begin
                ucnt_ff <= ucnt_ff + 8'h01;
            end
            pll_bad_ff <= (ucnt_ff >= ulimit_ff);
            sync_ok_ff <= nxt_sync_ok;
        end
    end

    // Detector results with independent bypasses
    // both bits defeat lock check
    wire lock_ok  = (lk_s && !pll_bad_ff) || (lforce_ff && lbypen_ff);
    wire sync_ok  = sync_ok_ff || sync_byp_ff;
    wire clk_ok   = !clk_missing || clk_def_ff;
    wire standby  = lvds_pd_ff || pll_pd_ff;
    wire pwr_good = panel_on_request_ff && !standby && clk_ok && lock_ok && sync_ok;

    // Timer loads in ms, floored at the shortest period
    function automatic logic [11:0] ms_load(input logic [11:0] prod);
        ms_load = (prod < 12'(T_MIN_MS)) ? 12'(T_MIN_MS) : prod;
    endfunction

    wire [11:0] ld_t1 = ms_load(12'({3'h0, tpon_ff} * T1_STEP_MS));
    wire [11:0] ld_t2 = ms_load(12'({5'h00, tpble_ff} * T2_STEP_MS));
    wire [11:0] ld_t3 = ms_load(12'({5'h00, tpbld_ff} * T3_STEP_MS));
    wire [11:0] ld_t4 = ms_load(12'({3'h0, tpoff_ff} * T4_STEP_MS));
    wire [11:0] ld_t5 = ms_load(12'({6'h00, tppwd_ff} * T5_STEP_MS));

    // Sequencer
    lpp_seq_e    st_ff, nxt_st;
    logic [11:0] tmr_ff, nxt_ld;
    logic [15:0] pre_ff;
    logic        load;
    wire         tdone   = (tmr_ff == 12'h000);
    wire         ms_tick = (pre_ff == 16'(MS_CYC_P - 1));

    always_comb begin
        nxt_st = st_ff;
        nxt_ld = 12'h000;
        load   = 1'b0;
        unique case (st_ff)
            SQ_OFF: if (pwr_good) begin
                nxt_st = SQ_T1;
                nxt_ld = ld_t1;
                load   = 1'b1;
            end
            SQ_T1, SQ_T2, SQ_ON: begin
                if (!pwr_good) begin
                    nxt_st = SQ_T3;
                    nxt_ld = ld_t3;
                    load   = 1'b1;
                end else if (st_ff == SQ_T1 && tdone) begin
                    nxt_st = SQ_T2;
                    nxt_ld = ld_t2;
                    load   = 1'b1;
                end else if (st_ff == SQ_T2 && tdone) begin
                    nxt_st = SQ_ON;
                end
            end
            SQ_T3: if (tdone) begin
                nxt_st = SQ_T4;
                nxt_ld = ld_t4;
                load   = 1'b1;
            end
            SQ_T4: if (tdone) begin
                nxt_st = SQ_T5;
                nxt_ld = ld_t5;
                load   = 1'b1;
            end
            SQ_T5: if (tdone) begin
                nxt_st = SQ_OFF;
            end
            default: nxt_st = SQ_OFF;
        endcase
    end

    // Prescaler restarts on load, so each period is whole ms
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_ff  <= SQ_OFF;
            tmr_ff <= 12'h000;
            pre_ff <= 16'h0000;
        end else begin
            st_ff  <= nxt_st;
            pre_ff <= (load || ms_tick) ? 16'h0000 : pre_ff + 16'h0001;
            if (load) begin
                tmr_ff <= nxt_ld;
            end else if (ms_tick && !tdone) begin
                tmr_ff <= tmr_ff - 12'h001;
            end
        end
    end

    // Dither position: 2x2 ordered matrix
    logic xpar_ff, ypar_ff;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            xpar_ff <= 1'b0;
            ypar_ff <= 1'b0;
        end else begin
            if (hs_rise) xpar_ff <= 1'b0;
            else if (pck_rise && px_ff.de) xpar_ff <= !xpar_ff;
            if (vs_rise) ypar_ff <= 1'b0;
            else if (hs_rise) ypar_ff <= !ypar_ff;
        end
    end

    // add threshold, saturate, keep six bits
    function automatic logic [5:0] dith(input logic [7:0] c, input logic [1:0] t,
                                        input logic en);
        logic [8:0] s;
        s = {1'b0, c} + {7'h00, t};
        if (!en) dith = c[7:2];
        else     dith = s[8] ? 6'h3F : s[7:2];
    endfunction

    wire [1:0] thr    = {xpar_ff ^ ypar_ff, ypar_ff};
    wire       dth_en = !ddef_ff;
    wire       ldi    = wide_ff && ldi_ff;
    wire [5:0] r18    = dith(px_ff.r, thr, dth_en);
    wire [5:0] g18    = dith(px_ff.g, thr, dth_en);
    wire [5:0] b18    = dith(px_ff.b, thr, dth_en);

    // Low six bits carried on lanes 0-2 in wide mode; narrow mode carries the top six after optional dither
    // LDI moves MSBs up
    wire [5:0] rl = ldi ? px_ff.r[7:2] : (wide_ff ? px_ff.r[5:0] : r18);
    wire [5:0] gl = ldi ? px_ff.g[7:2] : (wide_ff ? px_ff.g[5:0] : g18);
    wire [5:0] bl = ldi ? px_ff.b[7:2] : (wide_ff ? px_ff.b[5:0] : b18);
    wire [5:0] ex = ldi ? {px_ff.b[1:0], px_ff.g[1:0], px_ff.r[1:0]}
                        : {px_ff.b[7:6], px_ff.g[7:6], px_ff.r[7:6]};

    wire [3:0][6:0] lanes = {
        {1'b0, wide_ff ? ex : 6'h00},
        {px_ff.de, px_ff.vs, px_ff.hs, bl[5:2]},
        {bl[1:0], gl[5:1]},
        {gl[0], rl}
    };

    // spread clock stays in the analog PLL
    wire data_on = (st_ff == SQ_T2) || (st_ff == SQ_ON) || (st_ff == SQ_T3);

    // Supply and backlight outputs from the next state, so they move with it
    // exactly two panel outputs
    wire nxt_supply = (nxt_st != SQ_OFF) && (nxt_st != SQ_T5);
    wire nxt_bkl    = (nxt_st == SQ_ON) && bl_allow_ff;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            serial_lane_o      <= '0;
            serial_lane_oe_o   <= 1'b0;
            panel_supply_en_o  <= 1'b0;
            backlight_en_out_o <= 1'b0;
            standby_o          <= 1'b0;
        end else begin
            serial_lane_o      <= data_on ? lanes : '0;
            serial_lane_oe_o   <= data_on || pulldn_ff;
            panel_supply_en_o  <= nxt_supply;
            backlight_en_out_o <= nxt_bkl;
            standby_o          <= standby;
        end
    end

    // Read mux, reserved bits zero
    logic [7:0] rmux;
    always_comb begin
        rmux = 8'h00;
        unique case (reg_addr_i)
            ADR_CLKDET: rmux[B_CLKDEF] = clk_def_ff;
            ADR_LVDSPD: rmux[B_LVDSPD] = lvds_pd_ff;
            ADR_FORMAT: begin
                rmux[B_WIDE] = wide_ff;
                rmux[B_DDEF] = ddef_ff;
                rmux[B_LDI]  = ldi_ff;
            end
            ADR_PROT:   rmux = {1'b0, sync_ok_ff, bl_allow_ff, lbypen_ff,
                                lforce_ff, lk_s, sync_byp_ff, panel_on_request_ff};
            ADR_TPON_L: rmux = tpon_ff[7:0];
            ADR_TPBLE:  rmux = {tpon_ff[8], tpble_ff};
            ADR_TPBLD:  rmux = {tpoff_ff[8], tpbld_ff};
            ADR_TPOFF:  rmux = tpoff_ff[7:0];
            ADR_TPPWD:  rmux = {2'h0, tppwd_ff};
            ADR_DRIVER: rmux[B_PULLDN] = pulldn_ff;
            ADR_PLLPD:  rmux[B_PLLPD]  = pll_pd_ff;
            ADR_ULIMIT: rmux = ulimit_ff;
            default:    rmux = 8'h00;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) reg_rdata_o <= 8'h00;
        else           reg_rdata_o <= reg_rd_i ? rmux : 8'h00;
    end
endmodule
